// >>> common/smsp_defines.vh
`ifndef SMSP_DEFINES_VH
`define SMSP_DEFINES_VH

// ----------------------------------------
// control port bit positions
// ----------------------------------------
`define SMSP_CTL_EN      0
`define SMSP_CTL_MASTER  1
`define SMSP_CTL_FDE     2
`define SMSP_CTL_FAULT   3
`define SMSP_CTL_WRITE_COLLISION_FLAG    4
`define SMSP_CTL_OVR     5
`define SMSP_CTL_DONE    6
`define SMSP_CTL_BUSY    7

// ----------------------------------------
// config port bit positions
// ----------------------------------------
`define SMSP_CFG_IDLE    0
`define SMSP_CFG_PHASE   1
`define SMSP_CFG_CHR     2
`define SMSP_CFG_SAL     6
`define SMSP_CFG_IRQEN   7

// ----------------------------------------
// reset values
// ----------------------------------------
`define SMSP_CTL_RESET   8'h00
`define SMSP_CFG_RESET   8'h00
`define SMSP_DIV_RESET   8'h00
`define SMSP_BUF_RESET   16'h0000

// ----------------------------------------
// character timing, in clock edges
// ----------------------------------------
`define SMSP_LAST_EDGE8  5'h0F
`define SMSP_LAST_EDGE16 5'h1F
`define SMSP_SYNC_STAGES 2

`endif

// >>> core/smsp_sync.v
`timescale 1ns/100ps
`include "smsp_defines.vh"

// two-stage synchroniser for pins from outside the clock domain
module smsp_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // ----------------------------------------
  // capture chain; only stable_reg reads meta_reg
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg   <= asyncIn;
      stable_reg <= meta_reg;
    end
  end

  assign syncOut = stable_reg;

endmodule // smsp_sync

// >>> core/smsp_core.v
`timescale 1ns/100ps
`include "smsp_defines.vh"

module smsp_core (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        ctlWrEn,
  input  wire [7:0]  ctlWrData,
  input  wire        cfgWrEn,
  input  wire [7:0]  cfgWrData,
  input  wire        divWrEn,
  input  wire [7:0]  divWrData,
  input  wire        bufWrEn,
  input  wire [15:0] bufWrData,
  input  wire        bufRdEn,
  output wire [7:0]  ctlRdData,
  output wire [7:0]  cfgRdData,
  output wire [7:0]  divRdData,
  output wire [15:0] bufRdData,
  output wire        portIrq,
  input  wire        masterSerialIn,
  output wire        masterSerialOut,
  output wire        masterSerialOutOe,
  output wire        masterSerialClock,
  output wire        masterSerialClockOe,
  input  wire        masterSelectInput,
  input  wire        slaveSerialIn,
  output wire        slaveSerialOut,
  output wire        slaveSerialOutOe,
  input  wire        slaveClockIn
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg        portEnable_reg,     portEnable_next;
  reg        masterRole_reg,     masterRole_next;
  reg        faultDetect_reg,    faultDetect_next;
  reg        faultFlag_reg,      faultFlag_next;
  reg        collision_reg,      collision_next;
  reg        overrun_reg,        overrun_next;
  reg        transferDone_reg,   transferDone_next;
  reg        busy_reg,           busy_next;
  reg        irqEnable_reg,      irqEnable_next;
  reg        selectLevel_reg,    selectLevel_next;
  reg        charLength_reg,     charLength_next;
  reg        samplePhase_reg,    samplePhase_next;
  reg        idleLevel_reg,      idleLevel_next;
  reg [7:0]  baudDivider_reg,    baudDivider_next;
  reg [7:0]  divCnt_reg,         divCnt_next;
  reg [4:0]  edgeCnt_reg,        edgeCnt_next;
  reg [15:0] shift_reg,          shift_next;
  reg        txBit_reg,          txBit_next;
  reg        sck_reg,            sck_next;
  reg [15:0] rxBuffer_reg,       rxBuffer_next;
  reg        rxFull_reg,         rxFull_next;
  reg        slvClkPrev_reg;
  reg        irq_reg;

  // reset word kept whole so single bits are picked by position
  localparam [7:0] CTL_RESET = `SMSP_CTL_RESET;

  wire [3:0] pinSync;
  wire       misoSync;
  wire       selSync;
  wire       mosiSync;
  wire       clkSync;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  smsp_sync #(
    .WIDTH (4)
  ) u_pinSync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .asyncIn ({slaveClockIn, slaveSerialIn, masterSelectInput, masterSerialIn}),
    .syncOut (pinSync)
  );

  assign misoSync = pinSync[0];
  assign selSync  = pinSync[1];
  assign mosiSync = pinSync[2];
  assign clkSync  = pinSync[3];

  // ----------------------------------------
  // decoded conditions
  // ----------------------------------------
  wire isMaster  = portEnable_reg & masterRole_reg;
  wire isSlave   = portEnable_reg & ~masterRole_reg;
  wire selActive = (selSync == selectLevel_reg);
  // in master role select only matters when detection is on; otherwise a free pin
  wire modeFault = isMaster & faultDetect_reg & selActive;
  wire lastEdge  = (edgeCnt_reg == (charLength_reg ? `SMSP_LAST_EDGE16
                                                   : `SMSP_LAST_EDGE8));
  // one half period per divider wrap gives core/(2*(div+1))
  wire divTick   = (divCnt_reg == baudDivider_reg);
  wire masterEdge = isMaster & busy_reg & divTick;
  // slave clock seen through the synchroniser, so it needs four cycles a bit
  wire slvLead   = isSlave & selActive & (slvClkPrev_reg == idleLevel_reg)
                   & (clkSync != idleLevel_reg);
  wire slvTrail  = isSlave & selActive & busy_reg
                   & (slvClkPrev_reg != idleLevel_reg)
                   & (clkSync == idleLevel_reg);
  wire anyEdge   = masterEdge | slvLead | slvTrail;
  wire leading   = ~edgeCnt_reg[0];
  // phase 0 samples on the leading edge, phase 1 on the trailing
  wire sampleNow = anyEdge & (leading ^ samplePhase_reg);
  wire outNow    = anyEdge & ~(leading ^ samplePhase_reg);
  wire serialIn  = isMaster ? misoSync : mosiSync;
  wire complete  = anyEdge & lastEdge;
  wire slvAbort  = isSlave & busy_reg & ~selActive;
  wire collide   = bufWrEn & busy_reg;
  wire loadBuf   = bufWrEn & ~busy_reg;
  wire ctlFault  = ctlWrData[`SMSP_CTL_FAULT];
  wire ctlWcol   = ctlWrData[`SMSP_CTL_WRITE_COLLISION_FLAG];
  wire ctlOvr    = ctlWrData[`SMSP_CTL_OVR];
  wire ctlDone   = ctlWrData[`SMSP_CTL_DONE];

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always @* begin
    portEnable_next   = ctlWrEn ? ctlWrData[`SMSP_CTL_EN] : portEnable_reg;
    masterRole_next   = ctlWrEn ? ctlWrData[`SMSP_CTL_MASTER] : masterRole_reg;
    faultDetect_next  = ctlWrEn ? ctlWrData[`SMSP_CTL_FDE] : faultDetect_reg;
    irqEnable_next    = cfgWrEn ? cfgWrData[`SMSP_CFG_IRQEN] : irqEnable_reg;
    selectLevel_next  = cfgWrEn ? cfgWrData[`SMSP_CFG_SAL] : selectLevel_reg;
    charLength_next   = cfgWrEn ? cfgWrData[`SMSP_CFG_CHR] : charLength_reg;
    samplePhase_next  = cfgWrEn ? cfgWrData[`SMSP_CFG_PHASE] : samplePhase_reg;
    idleLevel_next    = cfgWrEn ? cfgWrData[`SMSP_CFG_IDLE] : idleLevel_reg;
    baudDivider_next  = divWrEn ? divWrData : baudDivider_reg;
    // hardware set wins over a software clear in the same cycle
    faultFlag_next    = modeFault | (ctlWrEn ? ctlFault : faultFlag_reg);
    collision_next    = collide | (ctlWrEn ? ctlWcol : collision_reg);
    overrun_next      = (complete & rxFull_reg & ~bufRdEn)
                        | (ctlWrEn ? ctlOvr : overrun_reg);
    transferDone_next = complete | (ctlWrEn ? ctlDone : transferDone_reg);
    busy_next         = busy_reg;
    divCnt_next       = divCnt_reg;
    edgeCnt_next      = edgeCnt_reg;
    shift_next        = shift_reg;
    txBit_next        = txBit_reg;
    sck_next          = sck_reg;
    rxBuffer_next     = rxBuffer_reg;
    rxFull_next       = bufRdEn ? 1'b0 : rxFull_reg;

    // buffer write: straight into the shift register when idle
    if (loadBuf) begin
      shift_next = bufWrData;
      txBit_next = charLength_reg ? bufWrData[15] : bufWrData[7];
      if (isMaster) begin
        busy_next    = 1'b1;
        divCnt_next  = 8'h00;
        edgeCnt_next = 5'h00;
      end
    end

    // master baud counter runs only inside a character
    if (isMaster & busy_reg) begin
      divCnt_next = divTick ? 8'h00 : divCnt_reg + 8'h01;
      if (divTick) begin
        sck_next = ~sck_reg;
      end
    end else begin
      sck_next = idleLevel_reg;
    end

    // first leading edge under select opens a slave character
    if (slvLead & ~busy_reg) begin
      busy_next    = 1'b1;
      edgeCnt_next = 5'h00;
    end

    // shift: sample into lsb, present new msb on the opposite edge
    if (anyEdge) begin
      edgeCnt_next = edgeCnt_reg + 5'h01;
    end
    if (sampleNow) begin
      shift_next = {shift_reg[14:0], serialIn};
    end
    if (outNow) begin
      txBit_next = charLength_reg ? shift_reg[15] : shift_reg[7];
    end

    // end of character; buffer keeps older data when still unread
    if (complete) begin
      busy_next    = 1'b0;
      edgeCnt_next = 5'h00;
      // select stays asserted, next leading edge starts the next one
      if (~rxFull_reg | bufRdEn) begin
        rxBuffer_next = charLength_reg ? shift_next
                                       : {8'h00, shift_next[7:0]};
        rxFull_next   = 1'b1;
      end
    end

    // slave deselected mid-character: drop partial character
    if (slvAbort) begin
      busy_next    = 1'b0;
      edgeCnt_next = 5'h00;
    end

    // software disable stops any character in flight
    if (~portEnable_reg) begin
      busy_next    = 1'b0;
      edgeCnt_next = 5'h00;
    end

    // contention guard: leave the bus at once
    if (modeFault) begin
      masterRole_next = 1'b0;
      portEnable_next = 1'b0;
      busy_next       = 1'b0;
      edgeCnt_next    = 5'h00;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      portEnable_reg   <= CTL_RESET[`SMSP_CTL_EN];
      masterRole_reg   <= CTL_RESET[`SMSP_CTL_MASTER];
      faultDetect_reg  <= CTL_RESET[`SMSP_CTL_FDE];
      faultFlag_reg    <= 1'b0;
      collision_reg    <= 1'b0;
      overrun_reg      <= 1'b0;
      transferDone_reg <= 1'b0;
      busy_reg         <= 1'b0;
      irqEnable_reg    <= 1'b0;
      selectLevel_reg  <= 1'b0;
      charLength_reg   <= 1'b0;
      samplePhase_reg  <= 1'b0;
      idleLevel_reg    <= 1'b0;
      baudDivider_reg  <= `SMSP_DIV_RESET;
      divCnt_reg       <= 8'h00;
      edgeCnt_reg      <= 5'h00;
      shift_reg        <= `SMSP_BUF_RESET;
      txBit_reg        <= 1'b0;
      sck_reg          <= 1'b0;
      rxBuffer_reg     <= `SMSP_BUF_RESET;
      rxFull_reg       <= 1'b0;
      slvClkPrev_reg   <= 1'b0;
      irq_reg          <= 1'b0;
    end else begin
      portEnable_reg   <= portEnable_next;
      masterRole_reg   <= masterRole_next;
      faultDetect_reg  <= faultDetect_next;
      faultFlag_reg    <= faultFlag_next;
      collision_reg    <= collision_next;
      overrun_reg      <= overrun_next;
      transferDone_reg <= transferDone_next;
      busy_reg         <= busy_next;
      irqEnable_reg    <= irqEnable_next;
      selectLevel_reg  <= selectLevel_next;
      charLength_reg   <= charLength_next;
      samplePhase_reg  <= samplePhase_next;
      idleLevel_reg    <= idleLevel_next;
      baudDivider_reg  <= baudDivider_next;
      divCnt_reg       <= divCnt_next;
      edgeCnt_reg      <= edgeCnt_next;
      shift_reg        <= shift_next;
      txBit_reg        <= txBit_next;
      sck_reg          <= sck_next;
      rxBuffer_reg     <= rxBuffer_next;
      rxFull_reg       <= rxFull_next;
      slvClkPrev_reg   <= clkSync;
      // flags written to 1 by software interrupt too
      irq_reg          <= irqEnable_next & (faultFlag_next | collision_next
                          | overrun_next | transferDone_next);
    end
  end

  // ----------------------------------------
  // software view
  // ----------------------------------------
  assign ctlRdData = {busy_reg, transferDone_reg, overrun_reg, collision_reg,
                      faultFlag_reg, faultDetect_reg, masterRole_reg,
                      portEnable_reg};
  // unused config bits read as zero
  assign cfgRdData = {irqEnable_reg, selectLevel_reg, 3'b000, charLength_reg,
                      samplePhase_reg, idleLevel_reg};
  assign divRdData = baudDivider_reg;
  assign bufRdData = rxBuffer_reg;
  assign portIrq   = irq_reg;

  // ----------------------------------------
  // pins; select is never driven here
  // ----------------------------------------
  assign masterSerialOut     = txBit_reg;
  assign masterSerialOutOe   = isMaster;
  assign masterSerialClock   = sck_reg;
  assign masterSerialClockOe = isMaster;
  assign slaveSerialOut      = txBit_reg;
  assign slaveSerialOutOe    = isSlave & selActive;

endmodule // smsp_core

// >>> dv/smsp_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module smsp_asserts (
  input wire       clock,
  input wire       sys_rst,
  input wire       ctlWrEn,
  input wire       bufWrEn,
  input wire       masterSelectInput,
  input wire [7:0] ctlRdData,
  input wire [7:0] cfgRdData,
  input wire [7:0] divRdData,
  input wire       portIrq,
  input wire       masterSerialClock,
  input wire       masterSerialClockOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  reg       sckPrev_reg;
  reg       seen_reg;
  reg [8:0] gap_reg;
  // cycles since the last serial clock change inside a character
  always @(posedge clock) begin
    sckPrev_reg <= masterSerialClock;
    if (sys_rst || !ctlRdData[7]) begin
      seen_reg <= 1'b0;
      gap_reg  <= 9'h000;
    end else if (masterSerialClock != sckPrev_reg) begin
      seen_reg <= 1'b1;
      gap_reg  <= 9'h001;
    end else begin
      gap_reg <= gap_reg + 9'h001;
    end
  end
  // idle master without fault detect gets a buffer write
  sequence s_start;
    ctlRdData[2:0] == 3'h3 && !ctlRdData[7] && bufWrEn && !ctlWrEn;
  endsequence
  // select at the active level, seen through the two-flop synchroniser
  sequence s_fault;
    ctlRdData[2:0] == 3'h7 && !ctlWrEn && !$past(sys_rst) && !$past(sys_rst, 2)
      && $past(masterSelectInput, 2) == cfgRdData[6];
  endsequence
  a_write_starts: assert property (s_start |=> ctlRdData[7] [*8])
    else $error("buffer write started no transfer");
  a_busy_collide: assert property (bufWrEn && ctlRdData[7] |=> ctlRdData[4])
    else $error("write while busy left collision clear");
  a_fault_stops: assert property (s_fault |=> ctlRdData[1:0] == 2'h0 && ctlRdData[3])
    else $error("mode fault did not stop the port");
  a_fault_gated: assert property (
    !ctlRdData[2] && !ctlRdData[3] && !ctlWrEn |=> !ctlRdData[3])
    else $error("fault flag set with detection off");
  a_flags_stick: assert property (
    !ctlWrEn |=> (ctlRdData[6:3] & $past(ctlRdData[6:3])) == $past(ctlRdData[6:3]))
    else $error("flag cleared without software");
  a_done_at_end: assert property (
    $fell(ctlRdData[7]) && ctlRdData[1:0] == 2'h3 |-> ctlRdData[6])
    else $error("transfer ended without done flag");
  a_irq_raise: assert property (
    (cfgRdData[7] && ctlRdData[6:3] != 4'h0) [*2] |-> portIrq)
    else $error("interrupt missing");
  a_irq_quiet: assert property (
    (!cfgRdData[7] || ctlRdData[6:3] == 4'h0) [*2] |-> !portIrq)
    else $error("interrupt without cause");
  a_drive_role: assert property (
    masterSerialClockOe == (ctlRdData[0] && ctlRdData[1]))
    else $error("clock driven outside master role");
  a_half_period: assert property (
    ctlRdData[7] && ctlRdData[1] && seen_reg && masterSerialClock != sckPrev_reg
      |-> gap_reg == {1'b0, divRdData} + 9'h001)
    else $error("serial clock half period wrong");
endmodule // smsp_asserts

// >>> dv/smsp_slave_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side slave
// ----------------------------------------
module smsp_slave_model (
  input  wire        sck,
  input  wire        mosi,
  input  wire        selected,
  input  wire        idleLevel,
  input  wire        samplePhase,
  input  wire        wide,
  input  wire [15:0] txWord,
  output reg         miso,
  output reg  [15:0] rxWord
);
  integer idx;
  integer last;
  initial begin
    miso   = 1'b0;
    rxWord = 16'h0000;
  end
  // phase 0 needs the first bit ready before the first edge
  always @(posedge selected) begin
    last = wide ? 15 : 7;
    idx  = last;
    if (!samplePhase) begin
      miso = txWord[idx];
      idx  = idx - 1;
    end
  end
  // sample on one edge, shift on the other; wraps for the next character
  always @(sck) begin
    if (selected) begin
      if ((sck != idleLevel) ^ samplePhase) begin
        rxWord = {rxWord[14:0], mosi};
      end else begin
        miso = txWord[idx];
        idx  = (idx == 0) ? last : idx - 1;
      end
    end
  end
  // released line never keeps its last value
  always @(negedge selected) begin
    miso = ~miso;
  end
endmodule // smsp_slave_model

// >>> dv/spi_master_slave_port_test.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench
// ----------------------------------------
module spi_master_slave_port_test;
  reg         clock = 1'b0;
  reg         sys_rst = 1'b1;
  reg         ctlWrEn = 1'b0;
  reg         cfgWrEn = 1'b0;
  reg         divWrEn = 1'b0;
  reg         bufWrEn = 1'b0;
  reg         bufRdEn = 1'b0;
  reg         selIn = 1'b1;
  reg         slvSel = 1'b0;
  reg         doneSeen = 1'b0;
  reg  [15:0] wrData = 16'h0000;
  reg  [15:0] slvTx = 16'h0000;
  reg  [15:0] oldTx;
  reg  [7:0]  cfgNow = 8'h00;
  reg  [31:0] seed = 32'h00004999;
  reg  [31:0] expNow;
  reg  [31:0] expQ[$];
  wire [7:0]  ctlRd;
  wire [15:0] bufRd;
  wire [15:0] slvRx;
  wire        irq, mosi, sck, miso;
  wire        sMiso, sOe, mOe;
  wire [7:0]  cfgRd, divRd;
  reg         sClk = 1'b0;
  reg         sMosi = 1'b0;
  reg  [7:0]  sIn;
  integer     error_cnt = 0;
  integer     n_tests = 0;
  integer     cycles = 0;
  integer     m;
  smsp_core i_smsp_core (
    .clock(clock), .sys_rst(sys_rst), .ctlWrEn(ctlWrEn), .ctlWrData(wrData[7:0]),
    .cfgWrEn(cfgWrEn), .cfgWrData(wrData[7:0]), .divWrEn(divWrEn), .divWrData(wrData[7:0]),
    .bufWrEn(bufWrEn), .bufWrData(wrData), .bufRdEn(bufRdEn), .ctlRdData(ctlRd),
    .cfgRdData(cfgRd), .divRdData(divRd), .bufRdData(bufRd), .portIrq(irq),
    .masterSerialIn(miso), .masterSerialOut(mosi), .masterSerialOutOe(mOe),
    .masterSerialClock(sck), .masterSerialClockOe(), .masterSelectInput(selIn),
    .slaveSerialIn(sMosi), .slaveSerialOut(sMiso), .slaveSerialOutOe(sOe), .slaveClockIn(sClk));
  smsp_slave_model i_smsp_slave_model (
    .sck(sck), .mosi(mosi), .selected(slvSel), .idleLevel(cfgNow[0]),
    .samplePhase(cfgNow[1]), .wide(cfgNow[2]), .txWord(slvTx), .miso(miso), .rxWord(slvRx));
  always #12.5 clock = ~clock;
  function [31:0] xorshift(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xorshift = t ^ (t << 5);
    end
  endfunction
  task chk(input string what, input [15:0] exp, input [15:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    // a note never taken off means a character never completed
    chk("pending notes", 16'h0, 16'(expQ.size()));
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one write pulse: 0 control, 1 config, 2 divider, 3 buffer
  task wr(input integer which, input [15:0] v);
    @(negedge clock);
    {ctlWrEn, cfgWrEn, divWrEn, bufWrEn} = 4'h8 >> which;
    wrData = v;
    @(negedge clock);
    {ctlWrEn, cfgWrEn, divWrEn, bufWrEn} = 4'h0;
  endtask
  // one character; the watcher compares, this task frees and clears
  task xfer(input [15:0] tx, input [15:0] expBuf, input rd, input collide, input ovr);
    reg [15:0] mask;
    integer    k;
    begin
      mask = cfgNow[2] ? 16'hFFFF : 16'h00FF;
      expQ.push_back({expBuf & mask, tx & mask});
      wr(3, tx);
      if (collide) begin
        wr(3, ~tx);
        @(negedge clock);
        chk("collision", 16'h1, {15'h0, ctlRd[4]});
      end
      for (k = 0; k < 2000 && ctlRd[6] !== 1'b1; k = k + 1) @(negedge clock);
      chk("done", 16'h1, {15'h0, ctlRd[6]});
      @(negedge clock);
      chk("overrun", {15'h0, ovr}, {15'h0, ctlRd[5]});
      bufRdEn = rd;
      @(negedge clock);
      bufRdEn = 1'b0;
      wr(0, 16'h3);
    end
  endtask
  // far-side master for the slave role, mode 0, 8-bit, msb first
  // four clocks a half period, well above the synchroniser's two
  task slv_char(input [7:0] din, output [7:0] dout);
    integer b;
    begin
      dout = 8'h00;
      for (b = 7; b >= 0; b = b - 1) begin
        sMosi = din[b];
        repeat (4) @(negedge clock);
        dout = {dout[6:0], sMiso};
        sClk = 1'b1;
        // one buffer write inside the character must bounce
        if (b == 3) begin
          wr(3, 16'hFFFF);
        end else begin
          repeat (2) @(negedge clock);
        end
        repeat (2) @(negedge clock);
        sClk = 1'b0;
      end
      repeat (4) @(negedge clock);
    end
  endtask
  // watcher: oldest note against each completed character
  always @(negedge clock) begin
    if (ctlRd[6] === 1'b1 && !doneSeen && expQ.size() > 0) begin
      expNow = expQ.pop_front();
      chk("rx buffer", expNow[31:16], bufRd);
      chk("slave rx", expNow[15:0], slvRx & (cfgNow[2] ? 16'hFFFF : 16'h00FF));
    end
    doneSeen = (ctlRd[6] === 1'b1);
  end
  // hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    // four formats at both lengths, two characters under one select
    for (m = 0; m < 8; m = m + 1) begin
      slvSel = 1'b0;
      seed = xorshift(seed);
      cfgNow = {5'h10, m[2:0]};
      wr(1, {8'h00, cfgNow});
      chk("config", {8'h00, cfgNow}, {8'h00, cfgRd});
      wr(2, {14'h0, seed[1:0]} + 16'h2);
      chk("divider", {14'h0, seed[1:0]} + 16'h2, {8'h00, divRd});
      wr(0, 16'h3);
      slvTx = seed[31:16];
      slvSel = 1'b1;
      repeat (2) begin
        seed = xorshift(seed);
        xfer(seed[15:0], slvTx, 1'b1, m == 7, 1'b0);
      end
    end
    // unread buffer: the newer character is dropped
    xfer(16'h5A3C, slvTx, 1'b0, 1'b0, 1'b0);
    oldTx = slvTx;
    slvTx = ~slvTx;
    xfer(16'hC35A, oldTx, 1'b1, 1'b0, 1'b1);
    slvSel = 1'b0;
    // slave role, select active low; one write collides mid-character
    seed = xorshift(seed);
    wr(1, 16'h80);
    wr(0, 16'h1);
    wr(3, {8'h00, seed[7:0]});
    chk("slave quiet", 16'h0, {15'h0, sOe});
    selIn = 1'b0;
    slv_char(seed[15:8], sIn);
    chk("slave tx", {8'h00, seed[7:0]}, {8'h00, sIn});
    chk("slave rx", {8'h00, seed[15:8]}, bufRd);
    chk("slave collision", 16'h1, {15'h0, ctlRd[4]});
    chk("slave done", 16'h1, {15'h0, ctlRd[6]});
    chk("slave drive", 16'h1, {15'h0, sOe});
    selIn = 1'b1;
    // software sets each flag: interrupt, masking, clearing
    for (m = 3; m < 7; m = m + 1) begin
      wr(0, 16'h3 | (16'h1 << m));
      @(negedge clock);
      chk("irq set", 16'h1, {15'h0, irq});
      wr(1, 16'h07);
      @(negedge clock);
      chk("irq mask", 16'h0, {15'h0, irq});
      wr(1, 16'h87);
      wr(0, 16'h3);
      @(negedge clock);
      chk("irq clear", 16'h0, {15'h0, irq});
    end
    selIn = 1'b0;
    repeat (4) @(negedge clock);
    chk("fde off", 16'h3, {12'h0, ctlRd[3:0]});
    // fault detection at both active levels
    for (m = 0; m < 2; m = m + 1) begin
      wr(0, 16'h0);
      wr(1, {8'h00, 1'b1, m[0], 6'h07});
      selIn = ~m[0];
      repeat (3) @(negedge clock);
      wr(0, 16'h7);
      repeat (4) @(negedge clock);
      chk("no fault", 16'h7, {12'h0, ctlRd[3:0]});
      chk("mosi drive", 16'h1, {15'h0, mOe});
      selIn = m[0];
      repeat (4) @(negedge clock);
      chk("fault", 16'hC, {12'h0, ctlRd[3:0]});
      chk("mosi released", 16'h0, {15'h0, mOe});
    end
    close_out;
  end
endmodule // spi_master_slave_port_test
bind smsp_core smsp_asserts i_smsp_asserts (
  .clock, .sys_rst, .ctlWrEn, .bufWrEn, .masterSelectInput, .ctlRdData, .cfgRdData,
  .divRdData, .portIrq, .masterSerialClock, .masterSerialClockOe);
